// ==== core/bank2_pkg.sv ====
package bank2_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int FULL_W = 9;
	localparam int DMEM_AW = 9;
	localparam int PC_W = 13;
	localparam int LATCH_W = 5;
	localparam int JUMP_W = 11;
	localparam int FLAG_W = 3;

	// Full addresses of the third bank
	localparam logic [FULL_W-1:0] ADDR_INDIRECT = 9'h100;
	localparam logic [FULL_W-1:0] ADDR_TIMER = 9'h101;
	localparam logic [FULL_W-1:0] ADDR_PCL = 9'h102;
	localparam logic [FULL_W-1:0] ADDR_STATUS = 9'h103;
	localparam logic [FULL_W-1:0] ADDR_POINTER = 9'h104;
	localparam logic [FULL_W-1:0] ADDR_PORT = 9'h106;
	localparam logic [FULL_W-1:0] ADDR_LATCH = 9'h10A;
	localparam logic [FULL_W-1:0] ADDR_INTCTL = 9'h10B;
	localparam logic [1:0] BANK_TWO = 2'h2;

	// Field positions in core_flags_and_bank
	localparam int ST_IRP = 7;
	localparam int ST_RP1 = 6;
	localparam int ST_RP0 = 5;
	localparam int ST_TO = 4;
	localparam int ST_PD = 3;
	localparam int ST_LOW_W = 3;

	// Reset values and other constants
	localparam logic [DATA_W-1:0] STATUS_POR = 8'h18;
	localparam logic [2:0] STATUS_TOP_RST = 3'h0;
	localparam logic [DATA_W-1:0] STATUS_SW_MASK = 8'hE7;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [PC_W-1:0] PC_RST = 13'h0000;
	localparam logic [LATCH_W-1:0] LATCH_RST = 5'h00;
	localparam logic [DATA_W-1:0] INTCTL_POR = 8'h00;
	localparam logic [6:0] INTCTL_TOP_RST = 7'h00;
	localparam logic [DATA_W-1:0] POINTER_POR = 8'h00;
	localparam logic [DATA_W-1:0] PORT_POR = 8'h00;
	localparam logic [DATA_W-1:0] TIMER_POR = 8'h00;
	localparam logic [DATA_W-1:0] TIMER_MAX = 8'hFF;
	localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
	localparam logic [DATA_W-1:0] TIMER_ONE = 8'h01;
	localparam int INT_TIMER_FLAG = 2;
	localparam int LATCH_JUMP_LO = 3;
endpackage : bank2_pkg

// ==== core/bank2_dmem.sv ====
`timescale 1ns/1ns
module bank2_dmem (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic we_in,
	input wire logic [bank2_pkg::DMEM_AW-1:0] addr_in,
	input wire logic [bank2_pkg::DATA_W-1:0] wdata_in,
	input wire logic rd_in,
	input wire logic use_mem_in,
	input wire logic [bank2_pkg::DATA_W-1:0] side_data_in,
	output logic [bank2_pkg::DATA_W-1:0] rdata_out
);
	import bank2_pkg::*;

	logic [DATA_W-1:0] mem [0:(1<<DMEM_AW)-1];

	always_ff @(posedge clk_sys_in) begin
		if (we_in) begin
			mem[addr_in] <= wdata_in;
		end
	end

	// One read register serves both the array and the register file
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_out <= ZERO_BYTE;
		end else if (rd_in && use_mem_in) begin
			rdata_out <= mem[addr_in];
		end else if (rd_in) begin
			rdata_out <= side_data_in;
		end else begin
			rdata_out <= ZERO_BYTE;
		end
	end
endmodule : bank2_dmem

// ==== core/bank2_regs.sv ====
// Functional notes
// - Unimplemented locations and unimplemented bits inside registers read as zero.
// - Location 100h reaches data memory at the pointer address, no physical register.
// - Location 104h holds the indirect pointer used by indirect accesses.
// - Upper PC hidden; 5-bit latch at 10Ah feeds PC bits 12:8 on a PC low write; a jump takes only latch bits 4:3 into PC bits 12:11.
// - Indirect port, PC low, status, pointer, latch, interrupt control answer in any bank.
// - Status loads 0001 1xxx on power-on/brown-out, 000q quuu on other resets.
// - External reset pin and watchdog timeout are other resets, not power-up ones.
`timescale 1ns/1ns
module bank2_regs (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic [bank2_pkg::ADDR_W-1:0] addr_in,
	input wire logic [bank2_pkg::DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [bank2_pkg::DATA_W-1:0] rdata_out,
	input wire logic brownout_reset_in,
	input wire logic external_reset_pin_in,
	input wire logic wdt_timeout_in,
	input wire logic pc_step_in,
	input wire logic pc_jump_in,
	input wire logic [bank2_pkg::JUMP_W-1:0] jump_target_in,
	input wire logic timer_tick_in,
	input wire logic [bank2_pkg::FLAG_W-1:0] int_flag_set_in,
	input wire logic [bank2_pkg::DATA_W-1:0] port_pins_in,
	output logic [bank2_pkg::DATA_W-1:0] port_latch_out,
	output logic [bank2_pkg::PC_W-1:0] pc_out,
	output logic [bank2_pkg::DATA_W-1:0] status_out,
	output logic [bank2_pkg::DATA_W-1:0] intctl_out
);
	import bank2_pkg::*;

	logic [DATA_W-1:0] pointer;
	logic [LATCH_W-1:0] latch;
	logic [DATA_W-1:0] timer;
	logic [FULL_W-1:0] full_addr;
	logic bank2;
	logic por_soft;
	logic other_soft;
	logic sel_indirect;
	logic sel_timer;
	logic sel_pcl;
	logic sel_status;
	logic sel_pointer;
	logic sel_port;
	logic sel_latch;
	logic sel_intctl;
	logic sel_any;
	logic [DATA_W-1:0] next_rdata;
	logic [DMEM_AW-1:0] dmem_addr;
	logic [DATA_W-1:0] next_status_other;
	logic timer_wrap;
	logic [DATA_W-1:0] hw_set;

	// Bank bits from the status register extend the 7-bit operand
	assign full_addr = {status_out[ST_RP1:ST_RP0], addr_in};
	assign bank2 = (status_out[ST_RP1:ST_RP0] == BANK_TWO);

	// Mirrored locations compare only the operand bits
	assign sel_indirect = (addr_in == ADDR_INDIRECT[ADDR_W-1:0]);
	assign sel_pcl = (addr_in == ADDR_PCL[ADDR_W-1:0]);
	assign sel_status = (addr_in == ADDR_STATUS[ADDR_W-1:0]);
	assign sel_pointer = (addr_in == ADDR_POINTER[ADDR_W-1:0]);
	assign sel_latch = (addr_in == ADDR_LATCH[ADDR_W-1:0]);
	assign sel_intctl = (addr_in == ADDR_INTCTL[ADDR_W-1:0]);

	// Bank-local locations need the full address
	assign sel_timer = bank2 && (full_addr == ADDR_TIMER);
	assign sel_port = bank2 && (full_addr == ADDR_PORT);
	assign sel_any = sel_indirect | sel_timer | sel_pcl | sel_status | sel_pointer
		| sel_port | sel_latch | sel_intctl;

	// Reset causes seen by the clocked logic
	assign por_soft = brownout_reset_in;
	assign other_soft = !brownout_reset_in && (external_reset_pin_in || wdt_timeout_in);

	// Watchdog clears the time-out bit; both causes mark the core awake
	always_comb begin
		next_status_other = status_out;
		next_status_other[ST_IRP:ST_RP0] = STATUS_TOP_RST;
		next_status_other[ST_TO] = !wdt_timeout_in;
		next_status_other[ST_PD] = 1'b1;
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			status_out <= STATUS_POR;
		end else if (por_soft) begin
			status_out <= STATUS_POR;
		end else if (other_soft) begin
			status_out <= next_status_other;
		end else if (wr_in && sel_status) begin
			status_out <= (wdata_in & STATUS_SW_MASK) | (status_out & ~STATUS_SW_MASK);
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pointer <= POINTER_POR;
		end else if (por_soft) begin
			pointer <= POINTER_POR;
		end else if (!other_soft && wr_in && sel_pointer) begin
			pointer <= wdata_in;
		end
	end

	// Only five latch bits exist; bits 7:5 are never stored
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			latch <= LATCH_RST;
		end else if (por_soft || other_soft) begin
			latch <= LATCH_RST;
		end else if (wr_in && sel_latch) begin
			latch <= wdata_in[LATCH_W-1:0];
		end
	end

	// The upper PC is loaded from the latch on a PC low write; a jump takes only latch bits 4:3
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pc_out <= PC_RST;
		end else if (por_soft || other_soft) begin
			pc_out <= PC_RST;
		end else if (wr_in && sel_pcl) begin
			pc_out <= {latch, wdata_in};
		end else if (pc_jump_in) begin
			pc_out <= {latch[LATCH_W-1:LATCH_JUMP_LO], jump_target_in};
		end else if (pc_step_in) begin
			pc_out <= pc_out + PC_ONE;
		end
	end

	assign timer_wrap = timer_tick_in && (timer == TIMER_MAX) && !(wr_in && sel_timer);

	// Per-bit hardware set requests for interrupt_control_reg
	always_comb begin
		hw_set = {{(DATA_W-FLAG_W){1'b0}}, int_flag_set_in};
		hw_set[INT_TIMER_FLAG] = hw_set[INT_TIMER_FLAG] | timer_wrap;
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			timer <= TIMER_POR;
		end else if (por_soft) begin
			timer <= TIMER_POR;
		end else if (other_soft) begin
			timer <= timer;
		end else if (wr_in && sel_timer) begin
			timer <= wdata_in;
		end else if (timer_tick_in) begin
			timer <= timer + TIMER_ONE;
		end
	end

	// Hardware flag sets win over a software write in the same cycle
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			intctl_out <= INTCTL_POR;
		end else if (por_soft) begin
			intctl_out <= INTCTL_POR;
		end else if (other_soft) begin
			intctl_out <= {INTCTL_TOP_RST, intctl_out[0]};
		end else begin
			for (int i = 0; i < DATA_W; i++) begin
				if (hw_set[i]) begin
					intctl_out[i] <= 1'b1;
				end else if (wr_in && sel_intctl) begin
					intctl_out[i] <= wdata_in[i];
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			port_latch_out <= PORT_POR;
		end else if (por_soft) begin
			port_latch_out <= PORT_POR;
		end else if (!other_soft && wr_in && sel_port) begin
			port_latch_out <= wdata_in;
		end
	end

	// Indirect accesses use the bank bit and the pointer as the address
	assign dmem_addr = {status_out[ST_IRP], pointer};

	always_comb begin
		next_rdata = ZERO_BYTE;
		if (sel_timer) begin
			next_rdata = timer;
		end else if (sel_pcl) begin
			next_rdata = pc_out[DATA_W-1:0];
		end else if (sel_status) begin
			next_rdata = status_out;
		end else if (sel_pointer) begin
			next_rdata = pointer;
		end else if (sel_port) begin
			next_rdata = port_pins_in;
		end else if (sel_latch) begin
			next_rdata = {{(DATA_W-LATCH_W){1'b0}}, latch};
		end else if (sel_intctl) begin
			next_rdata = intctl_out;
		end
	end

	bank2_dmem u_dmem (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.we_in(wr_in && sel_indirect),
		.addr_in(dmem_addr),
		.wdata_in(wdata_in),
		.rd_in(rd_in),
		.use_mem_in(sel_indirect),
		.side_data_in(next_rdata),
		.rdata_out(rdata_out)
	);

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!nrst_in);

	a_unmapped_reads_zero: assert property (rd_in && !sel_any |=> rdata_out == ZERO_BYTE)
		else $error("unmapped location did not read zero");

	a_latch_upper_zero: assert property (
		rd_in && sel_latch |=> rdata_out[DATA_W-1:LATCH_W] == 3'h0
			&& rdata_out[LATCH_W-1:0] == $past(latch))
		else $error("pc latch read shows bits above five");

	property p_indirect_roundtrip;
		logic [DATA_W-1:0] d;
		(wr_in && sel_indirect && !brownout_reset_in, d = wdata_in) ##1
			(rd_in && sel_indirect && $stable(dmem_addr)) |=> rdata_out == d;
	endproperty
	a_indirect_memory: assert property (p_indirect_roundtrip)
		else $error("indirect write not seen by indirect read");

	a_indirect_no_reg: assert property (
		wr_in && sel_indirect && !brownout_reset_in && !other_soft
			|=> $stable(pointer) && $stable(latch) && $stable(status_out))
		else $error("indirect write touched a physical register");

	a_pointer_load: assert property (
		wr_in && sel_pointer && !brownout_reset_in && !other_soft |=> pointer == $past(wdata_in))
		else $error("pointer write not taken");

	a_pcl_transfer: assert property (
		wr_in && sel_pcl && !brownout_reset_in && !other_soft
			|=> pc_out == {$past(latch), $past(wdata_in)})
		else $error("pc low write did not transfer the latch");

	a_status_mirror: assert property (
		rd_in && sel_status |=> rdata_out == $past(status_out))
		else $error("status not readable in current bank");

	a_por_status: assert property (
		brownout_reset_in |=> status_out[ST_IRP:ST_PD] == STATUS_POR[ST_IRP:ST_PD])
		else $error("brown-out status value wrong");

	a_wdt_status: assert property (
		wdt_timeout_in && !brownout_reset_in |=> status_out[ST_IRP:ST_TO] == 4'h0
			&& status_out[ST_PD] && status_out[ST_LOW_W-1:0] == $past(status_out[ST_LOW_W-1:0]))
		else $error("watchdog status value wrong");

	a_ext_keep: assert property (
		external_reset_pin_in && !brownout_reset_in
			|=> $stable(pointer) && status_out[ST_TO] && pc_out == PC_RST)
		else $error("external reset used power-up values");

	a_bank_local: assert property (
		rd_in && !bank2 && (addr_in == ADDR_TIMER[ADDR_W-1:0]) |=> rdata_out == ZERO_BYTE)
		else $error("timer answered outside bank two");

	a_flag_set_wins: assert property (
		int_flag_set_in != 3'h0 && !brownout_reset_in && !other_soft
			|=> (intctl_out[FLAG_W-1:0] & $past(int_flag_set_in)) == $past(int_flag_set_in))
		else $error("hardware flag set lost to a write");

	a_timer_wrap_flag: assert property (
		timer_wrap && !brownout_reset_in && !other_soft |=> intctl_out[INT_TIMER_FLAG])
		else $error("timer wrap did not set its flag");

	a_rdata_idle: assert property (!rd_in |=> rdata_out == ZERO_BYTE)
		else $error("read data stood longer than one cycle");

	a_latch_load: assert property (
		wr_in && sel_latch && !brownout_reset_in && !other_soft
			|=> latch == $past(wdata_in[LATCH_W-1:0]))
		else $error("pc latch write not taken");

	a_jump_transfer: assert property (
		pc_jump_in && !(wr_in && sel_pcl) && !brownout_reset_in && !other_soft
			|=> pc_out == {$past(latch[LATCH_W-1:LATCH_JUMP_LO]), $past(jump_target_in)})
		else $error("jump did not take the latch bits");

	a_port_local: assert property (
		rd_in && !bank2 && (addr_in == ADDR_PORT[ADDR_W-1:0]) |=> rdata_out == ZERO_BYTE)
		else $error("port answered outside bank two");

	a_port_pins: assert property (
		rd_in && sel_port |=> rdata_out == $past(port_pins_in))
		else $error("port read did not show the pins");

	a_pointer_mirror: assert property (
		rd_in && sel_pointer |=> rdata_out == $past(pointer))
		else $error("pointer not readable in current bank");

	a_intctl_mirror: assert property (
		rd_in && sel_intctl |=> rdata_out == $past(intctl_out))
		else $error("interrupt control not readable in current bank");

	a_pcl_mirror: assert property (
		rd_in && sel_pcl |=> rdata_out == $past(pc_out[DATA_W-1:0]))
		else $error("pc low byte not readable in current bank");

	a_status_ro_bits: assert property (
		wr_in && sel_status && !brownout_reset_in && !other_soft
			|=> status_out[ST_TO:ST_PD] == $past(status_out[ST_TO:ST_PD]))
		else $error("status read-only bits took a write");

	a_ext_status: assert property (
		external_reset_pin_in && !wdt_timeout_in && !brownout_reset_in
			|=> status_out[ST_IRP:ST_PD] == STATUS_POR[ST_IRP:ST_PD])
		else $error("external reset status value wrong");

	a_por_values: assert property (
		brownout_reset_in |=> pointer == POINTER_POR && latch == LATCH_RST
			&& pc_out == PC_RST && timer == TIMER_POR && intctl_out == INTCTL_POR)
		else $error("brown-out did not load power-up values");

	a_other_pc: assert property (
		other_soft |=> pc_out == PC_RST && latch == LATCH_RST && $stable(timer))
		else $error("other reset values wrong");

	c_indirect_read: cover property (rd_in && sel_indirect ##1 rdata_out != ZERO_BYTE);
	c_flag_clash: cover property (wr_in && sel_intctl && int_flag_set_in != 3'h0);
	c_pcl_write: cover property (wr_in && sel_latch ##1 wr_in && sel_pcl);
	c_wdt_reset: cover property (wdt_timeout_in && !brownout_reset_in);
	c_bank2_timer: cover property (rd_in && sel_timer);
endmodule : bank2_regs

// ==== testbench/bank2_regs_tb.sv ====
`timescale 1ns/1ns
module bank2_regs_tb;
	import bank2_pkg::*;
	typedef struct packed {logic w; logic [6:0] a; logic [7:0] d; logic [7:0] e;} row_t;
	logic clk_sys_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [ADDR_W-1:0] addr_in = 7'h00;
	logic [DATA_W-1:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic brownout_reset_in = 1'b0;
	logic external_reset_pin_in = 1'b0;
	logic wdt_timeout_in = 1'b0;
	logic pc_step_in = 1'b0;
	logic pc_jump_in = 1'b0;
	logic [JUMP_W-1:0] jump_target_in = 11'h123;
	logic timer_tick_in = 1'b0;
	logic [FLAG_W-1:0] int_flag_set_in = 3'h0;
	logic [DATA_W-1:0] port_pins_in = 8'hC3;
	logic [DATA_W-1:0] rdata_out;
	logic [DATA_W-1:0] port_latch_out;
	logic [PC_W-1:0] pc_out;
	logic [DATA_W-1:0] status_out;
	logic [DATA_W-1:0] intctl_out;
	int err_count = 0;
	int checks = 0;
	// Write/read pairs through banks 2, 0 and 1; w=0 rows only read
	row_t rows [0:28] = '{
		'{1'b1, 7'h03, 8'h40, 8'h58}, '{1'b1, 7'h04, 8'hAA, 8'hAA},
		'{1'b1, 7'h00, 8'h66, 8'h66}, '{1'b1, 7'h04, 8'hAB, 8'hAB},
		'{1'b1, 7'h00, 8'h99, 8'h99}, '{1'b1, 7'h04, 8'hAA, 8'hAA},
		'{1'b0, 7'h00, 8'h00, 8'h66}, '{1'b1, 7'h0A, 8'hFF, 8'h1F},
		'{1'b1, 7'h0B, 8'h80, 8'h80}, '{1'b1, 7'h01, 8'h37, 8'h37},
		'{1'b1, 7'h02, 8'h34, 8'h34}, '{1'b1, 7'h06, 8'h5A, 8'hC3},
		'{1'b1, 7'h05, 8'hFF, 8'h00}, '{1'b1, 7'h07, 8'hFF, 8'h00},
		'{1'b1, 7'h08, 8'hFF, 8'h00}, '{1'b1, 7'h09, 8'hFF, 8'h00},
		'{1'b1, 7'h0C, 8'hFF, 8'h00}, '{1'b1, 7'h1F, 8'hFF, 8'h00},
		'{1'b1, 7'h03, 8'h00, 8'h18}, '{1'b0, 7'h04, 8'h00, 8'hAA},
		'{1'b0, 7'h0A, 8'h00, 8'h1F}, '{1'b0, 7'h0B, 8'h00, 8'h80},
		'{1'b0, 7'h02, 8'h00, 8'h34}, '{1'b0, 7'h00, 8'h00, 8'h66},
		'{1'b0, 7'h01, 8'h00, 8'h00}, '{1'b0, 7'h06, 8'h00, 8'h00},
		'{1'b1, 7'h03, 8'h20, 8'h38}, '{1'b0, 7'h06, 8'h00, 8'h00},
		'{1'b1, 7'h03, 8'h40, 8'h58}};

	bank2_regs bank2_regs_inst (
		.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.brownout_reset_in(brownout_reset_in), .external_reset_pin_in(external_reset_pin_in),
		.wdt_timeout_in(wdt_timeout_in), .pc_step_in(pc_step_in), .pc_jump_in(pc_jump_in),
		.jump_target_in(jump_target_in), .timer_tick_in(timer_tick_in),
		.int_flag_set_in(int_flag_set_in), .port_pins_in(port_pins_in),
		.port_latch_out(port_latch_out), .pc_out(pc_out), .status_out(status_out),
		.intctl_out(intctl_out)
	);

	initial begin
		forever #10 clk_sys_in = ~clk_sys_in;
	end

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic stop_test();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
	endtask : wr

	// Data stands one cycle after the strobe, then idles at zero
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		@(posedge clk_sys_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		@(negedge clk_sys_in);
		chk("rdata", {8'h00, e}, {8'h00, rdata_out});
		@(negedge clk_sys_in);
		chk("rdata_idle", 16'h0000, {8'h00, rdata_out});
	endtask : rd

	// Bits: brownout, external, watchdog, step, jump, tick, flag sets
	task automatic pulse(input logic [8:0] v);
		@(posedge clk_sys_in);
		{brownout_reset_in, external_reset_pin_in, wdt_timeout_in, pc_step_in, pc_jump_in,
			timer_tick_in, int_flag_set_in} <= v;
		@(posedge clk_sys_in);
		{brownout_reset_in, external_reset_pin_in, wdt_timeout_in, pc_step_in, pc_jump_in,
			timer_tick_in, int_flag_set_in} <= 9'h000;
		@(negedge clk_sys_in);
	endtask : pulse

	initial begin
		#200000;
		err_count++;
		stop_test();
	end

	initial begin
		repeat (8) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		@(negedge clk_sys_in);
		chk("status_por", {8'h00, STATUS_POR}, {8'h00, status_out});
		foreach (rows[i]) begin
			if (rows[i].w) begin
				wr(rows[i].a, rows[i].d);
			end
			rd(rows[i].a, rows[i].e);
		end
		chk("port_latch", {8'h00, 8'h5A}, {8'h00, port_latch_out});
		// Indirect bank bit selects the upper half of data memory
		wr(7'h03, 8'hC0);
		wr(7'h00, 8'h5C);
		rd(7'h00, 8'h5C);
		wr(7'h03, 8'h40);
		rd(7'h00, 8'h66);
		pulse(9'h010);
		chk("pc_jump", 16'h1923, {3'h0, pc_out});
		pulse(9'h020);
		chk("pc_step", 16'h1924, {3'h0, pc_out});
		pulse(9'h008);
		rd(7'h01, 8'h38);
		pulse(9'h001);
		chk("intctl_flag", 16'h0081, {8'h00, intctl_out});
		// Timer wrap sets its interrupt flag
		wr(7'h01, 8'hFF);
		pulse(9'h008);
		chk("intctl_wrap", 16'h0085, {8'h00, intctl_out});
		rd(7'h01, 8'h00);
		pulse(9'h040);
		chk("status_wdt", 16'h0008, {8'h00, status_out});
		chk("intctl_wdt", 16'h0001, {8'h00, intctl_out});
		chk("pc_wdt", 16'h0000, {3'h0, pc_out});
		// Hardware set and software clear in one cycle: the set wins
		@(posedge clk_sys_in);
		wr_in <= 1'b1;
		addr_in <= 7'h0B;
		wdata_in <= 8'h00;
		int_flag_set_in <= 3'h2;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
		int_flag_set_in <= 3'h0;
		@(negedge clk_sys_in);
		chk("intctl_set_wins", 16'h0002, {8'h00, intctl_out});
		rd(7'h04, 8'hAA);
		rd(7'h0A, 8'h00);
		wr(7'h03, 8'h07);
		rd(7'h03, 8'h0F);
		pulse(9'h080);
		chk("status_ext", 16'h001F, {8'h00, status_out});
		pulse(9'h100);
		chk("status_bor", 16'h0018, {8'h00, status_out});
		chk("intctl_bor", 16'h0000, {8'h00, intctl_out});
		rd(7'h04, 8'h00);
		pulse(9'h020);
		@(posedge clk_sys_in);
		nrst_in <= 1'b0;
		@(negedge clk_sys_in);
		chk("pc_nrst", 16'h0000, {3'h0, pc_out});
		chk("status_nrst", 16'h0018, {8'h00, status_out});
		@(posedge clk_sys_in);
		nrst_in <= 1'b1;
		rd(7'h0B, 8'h00);
		stop_test();
	end
endmodule : bank2_regs_tb
